/* verilog/spc_pkg.sv */
// Constants shared by the sleep and power controller: register map, field layout,
// sleep mode codes, wake timing and the controller state type.
// Assumes an 8-bit core data bus with a separate I/O address space below data space.
`default_nettype none

package spc_pkg;

  // ==========================================================================
  // Register map and address spaces
  // ==========================================================================
  localparam logic [15:0] SLEEP_CTL_DS_OFF = 16'h0053;
  localparam logic [15:0] CORE_CTL_DS_OFF  = 16'h0055;
  localparam logic [15:0] IO_SPACE_BIAS    = 16'h0020;
  localparam logic [7:0]  SLEEP_CTL_RESET  = 8'h00;
  localparam logic [7:0]  CORE_CTL_RESET   = 8'h00;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int SLEEP_ARM_BIT      = 0;
  localparam int MODE_SEL_LSB       = 1;
  localparam int MODE_SEL_MSB       = 3;
  localparam int SCAN_DIS_BIT       = 7;
  localparam int SLEEP_CTL_USED_MSB = 3;

  // ==========================================================================
  // Sleep mode codes
  // ==========================================================================
  localparam logic [2:0] MODE_IDLE      = 3'h0;
  localparam logic [2:0] MODE_ADC_NR    = 3'h1;
  localparam logic [2:0] MODE_PWR_DOWN  = 3'h2;
  localparam logic [2:0] MODE_PWR_SAVE  = 3'h3;
  localparam logic [2:0] MODE_RSVD_A    = 3'h4;
  localparam logic [2:0] MODE_RSVD_B    = 3'h5;
  localparam logic [2:0] MODE_STANDBY   = 3'h6;
  localparam logic [2:0] MODE_EXT_STBY  = 3'h7;

  // ==========================================================================
  // Timing in core clock cycles
  // ==========================================================================
  localparam int STANDBY_WAKE_CYCLES = 6;
  localparam int WAKE_HALT_CYCLES    = 4;
  localparam int TIMED_WRITE_CYCLES  = 4;
  localparam logic [2:0] STBY_CNT_LOAD = 3'(STANDBY_WAKE_CYCLES - 2);
  localparam logic [2:0] HALT_CNT_LOAD = 3'(WAKE_HALT_CYCLES - 1);
  localparam logic [2:0] TW_WIN_LOAD   = 3'(TIMED_WRITE_CYCLES);

  localparam int NUM_PERIPH = 8;

  // ==========================================================================
  // Controller state
  // ==========================================================================
  typedef enum logic [2:0] {
    S_RUN,
    S_SLEEP,
    S_COUNT,
    S_OSC,
    S_HALT
  } spc_state_t;

endpackage

`default_nettype wire

/* verilog/spc_sleep_power_ctrl.sv */
// Sleep mode and power controller: sleep entry and wake sequencing, clock domain
// gating, per-peripheral clock stop, analog enables and the scan port disable bit.
// Assumes the core bus, sleep strobe, wake request and fuse levels are synchronous
// to CORE_CLK; the oscillator start-up time is reported through OSC_READY.
`timescale 1ns/1ps
`default_nettype none

module spc_sleep_power_ctrl (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [15:0] BUS_ADDR,
  input  wire logic        BUS_IO_SPACE,
  input  wire logic        BUS_WE,
  input  wire logic        BUS_RE,
  input  wire logic [7:0]  BUS_WDATA,
  output logic      [7:0]  BUS_RDATA,
  input  wire logic        SLEEP_EXEC,
  input  wire logic        WAKE_EVENT,
  input  wire logic        OSC_READY,
  input  wire logic        XTAL_CLOCK_OPT,
  input  wire logic        DEBUG_FUSE,
  input  wire logic        SCAN_PORT_FUSE,
  input  wire logic        BROWNOUT_FUSE_EN,
  input  wire logic        WATCHDOG_ON,
  input  wire logic [7:0]  PERIPH_STOP,
  input  wire logic        ADC_ENABLE,
  input  wire logic        ADC_CONV_START,
  input  wire logic        ACOMP_ENABLE,
  input  wire logic        ACOMP_USES_VREF,
  output logic             CPU_CLK_EN,
  output logic             FLASH_CLK_EN,
  output logic             IO_CLK_EN,
  output logic             ADC_CLK_EN,
  output logic             ASYNC_CLK_EN,
  output logic             OSC_EN,
  output logic      [7:0]  PERIPH_CLK_EN,
  output logic      [7:0]  PERIPH_ACCESS_EN,
  output logic             CPU_HOLD,
  output logic             SLEEPING,
  output logic             ADC_POWER_EN,
  output logic             ADC_EXT_CONV,
  output logic             ACOMP_POWER_EN,
  output logic             VREF_EN,
  output logic             INBUF_EN,
  output logic             BOD_EN,
  output logic             WDT_EN,
  output logic             SCAN_PORT_EN,
  output logic             DEBUG_EN
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================

  // Matches a register either by its data-space offset or by its I/O address.
  function automatic logic reg_hit(input logic [15:0] addr, input logic io_space,
                                   input logic [15:0] ds_off);
    logic [15:0] want;
    want = io_space ? 16'(ds_off - spc_pkg::IO_SPACE_BIAS) : ds_off;
    return addr == want;
  endfunction

  // Reserved codes are refused so that a stray sleep never stops the core.
  function automatic logic mode_valid(input logic [2:0] m);
    return (m != spc_pkg::MODE_RSVD_A) && (m != spc_pkg::MODE_RSVD_B);
  endfunction

  // Standby variants need a running crystal; otherwise fall back to the stopped mode.
  function automatic logic [2:0] eff_mode(input logic [2:0] m, input logic xtal);
    logic [2:0] r;
    r = m;
    if (!xtal && m == spc_pkg::MODE_STANDBY) begin
      r = spc_pkg::MODE_PWR_DOWN;
    end else if (!xtal && m == spc_pkg::MODE_EXT_STBY) begin
      r = spc_pkg::MODE_PWR_SAVE;
    end
    return r;
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    spc_pkg::spc_state_t state;
    logic [2:0]          mode;
    logic [2:0]          cnt;
    logic [3:0]          sleep_ctl;
    logic                scan_dis;
    logic                tw_pend;
    logic                tw_val;
    logic [2:0]          tw_win;
    logic                adc_prev;
    logic                ext_conv;
    logic [7:0]          rdata;
  } spc_regs_t;

  spc_regs_t cur;
  spc_regs_t next_cur;

  logic hit_sleep;
  logic hit_core;
  logic wr_sleep;
  logic wr_core;
  logic osc_kept;

  assign hit_sleep = reg_hit(BUS_ADDR, BUS_IO_SPACE, spc_pkg::SLEEP_CTL_DS_OFF);
  assign hit_core  = reg_hit(BUS_ADDR, BUS_IO_SPACE, spc_pkg::CORE_CTL_DS_OFF);
  assign wr_sleep  = BUS_WE && hit_sleep;
  assign wr_core   = BUS_WE && hit_core;

  // The oscillator is left running in the light modes, in standby and under debug.
  assign osc_kept = (cur.mode == spc_pkg::MODE_IDLE) || (cur.mode == spc_pkg::MODE_ADC_NR) ||
                    (cur.mode == spc_pkg::MODE_STANDBY) || (cur.mode == spc_pkg::MODE_EXT_STBY) ||
                    DEBUG_FUSE;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================

  // Bus, timed write, sleep sequencing and converter tracking in one pass.
  always_comb begin
    next_cur = cur;

    // Registered read data; unmapped addresses read as zero.
    next_cur.rdata = 8'h00;
    if (BUS_RE && hit_sleep) begin
      next_cur.rdata = {{(7 - spc_pkg::SLEEP_CTL_USED_MSB){1'b0}}, cur.sleep_ctl};
    end else if (BUS_RE && hit_core) begin
      next_cur.rdata = {cur.scan_dis, 7'h00};
    end

    if (wr_sleep) begin
      next_cur.sleep_ctl = BUS_WDATA[spc_pkg::SLEEP_CTL_USED_MSB:0];
    end

    // Second equal write inside the window commits; anything else restarts it.
    if (wr_core) begin
      if (cur.tw_pend && cur.tw_win != 3'h0 &&
          BUS_WDATA[spc_pkg::SCAN_DIS_BIT] == cur.tw_val) begin
        next_cur.scan_dis = cur.tw_val;
        next_cur.tw_pend  = 1'b0;
        next_cur.tw_win   = 3'h0;
      end else begin
        next_cur.tw_pend = 1'b1;
        next_cur.tw_val  = BUS_WDATA[spc_pkg::SCAN_DIS_BIT];
        next_cur.tw_win  = spc_pkg::TW_WIN_LOAD;
      end
    end else if (cur.tw_win != 3'h0) begin
      next_cur.tw_win = 3'(cur.tw_win - 3'h1);
      if (cur.tw_win == 3'h1) begin
        next_cur.tw_pend = 1'b0;
      end
    end

    // A fresh enable after an off period needs an extended conversion; set wins.
    next_cur.adc_prev = ADC_ENABLE;
    if (ADC_ENABLE && !cur.adc_prev) begin
      next_cur.ext_conv = 1'b1;
    end else if (ADC_CONV_START) begin
      next_cur.ext_conv = 1'b0;
    end

    unique case (cur.state)
      spc_pkg::S_RUN: begin
        // Unarmed or reserved requests fall through with no effect.
        if (SLEEP_EXEC && cur.sleep_ctl[spc_pkg::SLEEP_ARM_BIT] &&
            mode_valid(cur.sleep_ctl[spc_pkg::MODE_SEL_MSB:spc_pkg::MODE_SEL_LSB])) begin
          next_cur.state = spc_pkg::S_SLEEP;
          next_cur.mode  = eff_mode(cur.sleep_ctl[spc_pkg::MODE_SEL_MSB:spc_pkg::MODE_SEL_LSB],
                                    XTAL_CLOCK_OPT);
        end
      end
      spc_pkg::S_SLEEP: begin
        if (WAKE_EVENT) begin
          if (cur.mode == spc_pkg::MODE_IDLE || cur.mode == spc_pkg::MODE_ADC_NR) begin
            next_cur.state = spc_pkg::S_HALT;
            next_cur.cnt   = spc_pkg::HALT_CNT_LOAD;
          end else if (osc_kept) begin
            next_cur.state = spc_pkg::S_COUNT;
            next_cur.cnt   = spc_pkg::STBY_CNT_LOAD;
          end else begin
            next_cur.state = spc_pkg::S_OSC;
          end
        end
      end
      spc_pkg::S_COUNT: begin
        // Oscillator never stopped, so only the fixed short delay is spent.
        if (cur.cnt == 3'h0) begin
          next_cur.state = spc_pkg::S_HALT;
          next_cur.cnt   = spc_pkg::HALT_CNT_LOAD;
        end else begin
          next_cur.cnt = 3'(cur.cnt - 3'h1);
        end
      end
      spc_pkg::S_OSC: begin
        if (OSC_READY) begin
          next_cur.state = spc_pkg::S_HALT;
          next_cur.cnt   = spc_pkg::HALT_CNT_LOAD;
        end
      end
      spc_pkg::S_HALT: begin
        if (cur.cnt == 3'h0) begin
          next_cur.state = spc_pkg::S_RUN;
        end else begin
          next_cur.cnt = 3'(cur.cnt - 3'h1);
        end
      end
      default: begin
        next_cur.state = spc_pkg::S_RUN;
      end
    endcase
  end

  // Single register stage for all controller state.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cur <= '{state: spc_pkg::S_RUN, mode: spc_pkg::MODE_IDLE, cnt: 3'h0,
               sleep_ctl: spc_pkg::SLEEP_CTL_RESET[3:0],
               scan_dis: spc_pkg::CORE_CTL_RESET[spc_pkg::SCAN_DIS_BIT],
               tw_pend: 1'b0, tw_val: 1'b0, tw_win: 3'h0, adc_prev: 1'b0,
               ext_conv: 1'b0, rdata: 8'h00};
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // Clock domain gating
  // ==========================================================================
  logic asleep;
  logic async_mode;

  assign asleep     = (cur.state == spc_pkg::S_SLEEP) || (cur.state == spc_pkg::S_COUNT) ||
                      (cur.state == spc_pkg::S_OSC);
  assign async_mode = (cur.mode == spc_pkg::MODE_IDLE) || (cur.mode == spc_pkg::MODE_ADC_NR) ||
                      (cur.mode == spc_pkg::MODE_PWR_SAVE) || (cur.mode == spc_pkg::MODE_EXT_STBY);

  // Power-down and standby leave no generated clock running.
  assign CPU_CLK_EN   = !asleep;
  assign FLASH_CLK_EN = !asleep;
  assign IO_CLK_EN    = !asleep || (cur.mode == spc_pkg::MODE_IDLE);
  assign ADC_CLK_EN   = !asleep || (cur.mode == spc_pkg::MODE_IDLE) ||
                        (cur.mode == spc_pkg::MODE_ADC_NR);
  assign ASYNC_CLK_EN = !asleep || async_mode;
  assign OSC_EN       = !asleep || (cur.state == spc_pkg::S_OSC) || osc_kept;
  assign SLEEPING     = asleep;
  assign CPU_HOLD     = (cur.state == spc_pkg::S_HALT);

  // Peripheral clocks ride on the I/O clock, so deeper modes stop them anyway.
  assign PERIPH_CLK_EN    = IO_CLK_EN ? ~PERIPH_STOP : 8'h00;
  assign PERIPH_ACCESS_EN = ~PERIPH_STOP;

  // ==========================================================================
  // Analog, input buffer and debug enables
  // ==========================================================================

  // The reference follows its users; a comparator wired to it keeps it on in sleep.
  assign ADC_POWER_EN   = ADC_ENABLE;
  assign ADC_EXT_CONV   = cur.ext_conv;
  assign ACOMP_POWER_EN = ACOMP_ENABLE && (!asleep || cur.mode == spc_pkg::MODE_IDLE ||
                                           cur.mode == spc_pkg::MODE_ADC_NR);
  assign VREF_EN        = BROWNOUT_FUSE_EN || ADC_ENABLE ||
                          (ACOMP_ENABLE && ACOMP_USES_VREF);
  assign INBUF_EN       = IO_CLK_EN || ADC_CLK_EN;
  assign BOD_EN         = BROWNOUT_FUSE_EN;
  assign WDT_EN         = WATCHDOG_ON;
  assign SCAN_PORT_EN   = SCAN_PORT_FUSE && !cur.scan_dis;
  assign DEBUG_EN       = DEBUG_FUSE && SCAN_PORT_FUSE && !cur.scan_dis;
  assign BUS_RDATA      = cur.rdata;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_standby_wake_six: assert property ((cur.state == spc_pkg::S_SLEEP) &&
      (cur.mode == spc_pkg::MODE_STANDBY) && WAKE_EVENT |->
      !CPU_CLK_EN ##1 (!CPU_CLK_EN)[*5] ##1 CPU_CLK_EN)
    else $error("standby wake did not resume after six cycles");

  a_ext_standby_wake: assert property ((cur.state == spc_pkg::S_SLEEP) &&
      (cur.mode == spc_pkg::MODE_EXT_STBY) && WAKE_EVENT |-> ##6 CPU_CLK_EN && ASYNC_CLK_EN)
    else $error("extended standby wake not six cycles");

  a_standby_osc_on: assert property (asleep && (cur.mode == spc_pkg::MODE_STANDBY) |->
      OSC_EN && !IO_CLK_EN && !ASYNC_CLK_EN)
    else $error("standby clocks wrong");

  a_halt_four: assert property ($rose(CPU_HOLD) |-> CPU_HOLD[*4] ##1 !CPU_HOLD)
    else $error("wake hold not four cycles");

  a_arm_required: assert property (SLEEP_EXEC &&
      (!cur.sleep_ctl[spc_pkg::SLEEP_ARM_BIT] ||
       !mode_valid(cur.sleep_ctl[spc_pkg::MODE_SEL_MSB:spc_pkg::MODE_SEL_LSB])) &&
      (cur.state == spc_pkg::S_RUN) |=> CPU_CLK_EN)
    else $error("sleep entered while unarmed or reserved");

  a_periph_stop: assert property (((PERIPH_CLK_EN | PERIPH_ACCESS_EN) & PERIPH_STOP) == 8'h00)
    else $error("stopped peripheral still clocked or accessible");

  a_periph_deep: assert property (asleep && (cur.mode != spc_pkg::MODE_IDLE) |->
      PERIPH_CLK_EN == 8'h00)
    else $error("peripheral clock runs in deep sleep");

  a_scan_change: assert property ($changed(cur.scan_dis) |->
      $past(wr_core) && $past(cur.tw_pend) && $past(cur.tw_win) != 3'h0)
    else $error("scan disable changed without timed write");

  a_scan_enable: assert property (SCAN_PORT_EN == (SCAN_PORT_FUSE && !cur.scan_dis) &&
      !(cur.scan_dis && DEBUG_EN))
    else $error("scan port enable wrong");

  a_inbuf_off: assert property (!IO_CLK_EN && !ADC_CLK_EN |-> !INBUF_EN)
    else $error("input buffers on with clocks stopped");

  a_acomp_off: assert property (asleep && (cur.mode > spc_pkg::MODE_ADC_NR) |->
      !ACOMP_POWER_EN)
    else $error("comparator not disabled in deep sleep");

  a_vref_users: assert property (VREF_EN == (BOD_EN || ADC_POWER_EN ||
      (ACOMP_ENABLE && ACOMP_USES_VREF)))
    else $error("reference enable does not follow its users");

  a_debug_osc: assert property (asleep && DEBUG_FUSE |-> OSC_EN)
    else $error("debug fuse lost main oscillator in sleep");

  a_pdown_clocks: assert property (asleep && (cur.mode == spc_pkg::MODE_PWR_DOWN) &&
      !DEBUG_FUSE && (cur.state == spc_pkg::S_SLEEP) |->
      !(IO_CLK_EN || ADC_CLK_EN || ASYNC_CLK_EN || OSC_EN))
    else $error("power-down left a clock running");

  a_ext_conv_set: assert property ($rose(ADC_ENABLE) |=> ADC_EXT_CONV)
    else $error("re-enabled converter not flagged for extended conversion");

  c_standby_wake: cover property ((cur.state == spc_pkg::S_COUNT) ##[1:8] CPU_HOLD);
  c_pdown_wake: cover property ((cur.state == spc_pkg::S_OSC) ##[1:20] CPU_HOLD);
  c_scan_commit: cover property (wr_core ##[1:4] $changed(cur.scan_dis));
  c_idle_sleep: cover property (asleep && (cur.mode == spc_pkg::MODE_IDLE) ##1 CPU_HOLD);

endmodule

`default_nettype wire

/* testbench/spc_far_model.sv */
// Far-side model: a peripheral counting on its gated clock, and the main
// oscillator start-up seen by the controller.
// Assumes it runs on the controller clock.
`timescale 1ns/1ps
`default_nettype none
module spc_far_model #(
  parameter int OSC_START = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       osc_en,
  input  wire logic       periph_en,
  output logic            osc_ready,
  output logic      [7:0] periph_count
);
  // =========================================================================
  // Oscillator and peripheral
  // =========================================================================
  logic [3:0] osc_cnt;
  // The oscillator restarts from zero each time it is stopped.
  assign osc_ready = (osc_cnt == 4'(OSC_START));
  // The counter holds its value while its clock is stopped.
  always_ff @(posedge clk) begin
    if (rst || !osc_en) osc_cnt <= 4'h0;
    else if (!osc_ready) osc_cnt <= osc_cnt + 4'h1;
    if (rst) periph_count <= 8'h00;
    else if (periph_en) periph_count <= periph_count + 8'h01;
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the sleep and power controller.
// Assumes the far-side model sits on the oscillator and peripheral 0 clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, rst = 1, io = 0, we = 0, re = 0, slp = 0, wake = 0;
  logic        xtal = 1, dbg = 1, sfuse = 1, bod = 1, wdt = 1;
  logic        adc = 1, conv = 0, acmp = 1, auv = 1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wd = 8'h00, stop = 8'h00, rd, pclk, pacc, cnt;
  logic        cpu_en, io_en, adc_en, as_en, osc_en, hold, slping, adc_pw, ext, flash_en;
  logic        acp, vref, inbuf, boden, wdten, scan, dbgen, osc_rdy;
  int          miscompares = 0, compares = 0;
  spc_sleep_power_ctrl dut (.CORE_CLK(clk), .RST(rst), .BUS_ADDR(addr), .BUS_IO_SPACE(io),
    .BUS_WE(we), .BUS_RE(re), .BUS_WDATA(wd), .BUS_RDATA(rd), .SLEEP_EXEC(slp),
    .WAKE_EVENT(wake), .OSC_READY(osc_rdy), .XTAL_CLOCK_OPT(xtal), .DEBUG_FUSE(dbg),
    .SCAN_PORT_FUSE(sfuse), .BROWNOUT_FUSE_EN(bod), .WATCHDOG_ON(wdt), .PERIPH_STOP(stop),
    .ADC_ENABLE(adc), .ADC_CONV_START(conv), .ACOMP_ENABLE(acmp), .ACOMP_USES_VREF(auv),
    .CPU_CLK_EN(cpu_en), .FLASH_CLK_EN(flash_en), .IO_CLK_EN(io_en), .ADC_CLK_EN(adc_en),
    .ASYNC_CLK_EN(as_en), .OSC_EN(osc_en), .PERIPH_CLK_EN(pclk), .PERIPH_ACCESS_EN(pacc),
    .CPU_HOLD(hold), .SLEEPING(slping), .ADC_POWER_EN(adc_pw), .ADC_EXT_CONV(ext),
    .ACOMP_POWER_EN(acp), .VREF_EN(vref), .INBUF_EN(inbuf), .BOD_EN(boden),
    .WDT_EN(wdten), .SCAN_PORT_EN(scan), .DEBUG_EN(dbgen));
  spc_far_model #(.OSC_START(3)) far (.clk(clk), .rst(rst), .osc_en(osc_en),
    .periph_en(pclk[0]), .osc_ready(osc_rdy), .periph_count(cnt));
  // =========================================================================
  // Clock, access tasks and compares
  // =========================================================================
  // The clock toggles every 25 ns half period, for a 50 ns period.
  always #25 clk = ~clk;
  // Inputs move 2 ns after the edge, so no edge ever races them.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // A write leaves one idle cycle so back-to-back calls never touch a strobe twice.
  task automatic wr(input logic [15:0] a, input logic s, input logic [7:0] d);
    addr = a; io = s; wd = d; we = 1; cyc(1); we = 0; cyc(1);
  endtask
  // Read data is registered and shows in the cycle after the strobe.
  task automatic rdc(input logic [15:0] a, input logic s, input logic [7:0] e);
    addr = a; io = s; re = 1; cyc(1); re = 0; chk8("rdata", e, rd); cyc(1);
  endtask
  // One sleep attempt in mode m, then a wake with its timing measured.
  task automatic run_mode(input logic [2:0] m, input logic x, d, a);
    logic ok, keep;
    int   n, h;
    ok = a && (m[2:1] != 2'b10);
    // The light modes never stop the main oscillator either.
    keep = (x && m[2:1] == 2'b11) || d || m[2:1] == 2'b00;
    xtal = x; dbg = d;
    wr(16'h0053, 1'b0, {4'h0, m, a});
    slp = 1; cyc(1); slp = 0;
    chk1("sleeping", ok, slping);
    chk1("cpu_clk", !ok, cpu_en);
    chk1("flash_clk", !ok, flash_en);
    if (ok) begin
      chk1("io_clk", m == 3'h0, io_en);
      chk8("periph_clk", (m == 3'h0) ? 8'hFF : 8'h00, pclk);
      chk1("adc_clk", m <= 3'h1, adc_en);
      chk1("async_clk", m <= 3'h1 || m[1:0] == 2'b11, as_en);
      chk1("inbuf", m <= 3'h1, inbuf);
      chk1("acomp", m <= 3'h1, acp);
      chk1("osc", keep, osc_en);
      chk1("kept_on", 1'b1, adc_pw & vref & boden & wdten);
      wake = 1; cyc(1); wake = 0;
      n = 1;
      while (!cpu_en && n < 100) begin
        cyc(1);
        n++;
      end
      chk8("wake_cyc", (m <= 3'h1) ? 8'd1 : keep ? 8'd6 : 8'd5, n[7:0]);
      h = 0;
      while (hold && h < 20) begin
        h++;
        cyc(1);
      end
      chk8("hold_cyc", 8'd4, h[7:0]);
    end
    wr(16'h0053, 1'b0, 8'h00);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // =========================================================================
  // Test sequence and watchdog
  // =========================================================================
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    cyc(8); rst = 0;
    rdc(16'h0053, 1'b0, 8'h00);
    rdc(16'h0055, 1'b0, 8'h00);
    wr(16'h0033, 1'b1, 8'hFF);
    rdc(16'h0053, 1'b0, 8'h0F);
    rdc(16'h0033, 1'b1, 8'h0F);
    rdc(16'h0054, 1'b0, 8'h00);
    wr(16'h0053, 1'b0, 8'h00);
    chk1("scan_en", 1'b1, scan & dbgen);
    wr(16'h0055, 1'b0, 8'h80); cyc(3); wr(16'h0055, 1'b0, 8'h80);
    chk1("scan_en", 1'b1, scan);
    wr(16'h0035, 1'b1, 8'h80);
    chk1("scan_en", 1'b0, scan | dbgen);
    rdc(16'h0055, 1'b0, 8'h80);
    wr(16'h0055, 1'b0, 8'h00); wr(16'h0055, 1'b0, 8'h00);
    chk1("scan_en", 1'b1, scan);
    for (int i = 0; i < 8; i++) run_mode(i[2:0], 1'b1, 1'b0, 1'b1);
    run_mode(3'h6, 1'b0, 1'b0, 1'b1);
    run_mode(3'h7, 1'b0, 1'b0, 1'b1);
    run_mode(3'h2, 1'b0, 1'b1, 1'b1);
    run_mode(3'h0, 1'b1, 1'b0, 1'b0);
    // Peripheral 0 counts every cycle until its clock is stopped, then holds.
    stop = 8'h01; cyc(1);
    chk8("periph_clk", 8'hFE, pclk & pacc);
    wd = cnt; cyc(4);
    chk8("frozen", wd, cnt);
    stop = 8'h00; cyc(2);
    chk8("resumed", wd + 8'h02, cnt);
    // A conversion start clears the flag set by the enable seen after reset, so the re-enable is seen.
    adc = 0; bod = 0; auv = 0; conv = 1; cyc(1); conv = 0;
    chk1("vref", 1'b0, vref);
    chk1("ext_conv", 1'b0, ext);
    auv = 1; cyc(1);
    chk1("vref", 1'b1, vref);
    adc = 1; cyc(1);
    chk1("ext_conv", 1'b1, ext);
    give_verdict;
  end
endmodule
`default_nettype wire
